/* core/ccss_regs.svh */
/*
 * Constants for the console control and single-step block: timing counts and
 * state encodings. Assumes a 100 MHz machine clock.
 */
`ifndef CCSS_REGS_SVH
`define CCSS_REGS_SVH

`define CCSS_CLK_MHZ 100
`define CCSS_STANDBY_S 120
`define CCSS_STANDBY_CYC (64'(`CCSS_STANDBY_S) * `CCSS_CLK_MHZ * 1000000)
`define CCSS_DEBOUNCE_US 5
`define CCSS_DEBOUNCE_CYC (`CCSS_DEBOUNCE_US * `CCSS_CLK_MHZ)
`define CCSS_STOP_FILT_US 2
`define CCSS_STOP_FILT_CYC (`CCSS_STOP_FILT_US * `CCSS_CLK_MHZ)
`define CCSS_STATE_IDLE 4'h8
`define CCSS_STATE_XFER 4'h3
`define CCSS_STATE_HOLD 4'h4
`define CCSS_BTN_COUNT 6
`define CCSS_BTN_PWR_ON 0
`define CCSS_BTN_PWR_OFF 1
`define CCSS_BTN_START 2
`define CCSS_BTN_LOAD 3
`define CCSS_BTN_FETCH 4
`define CCSS_BTN_EXEC 5

`endif

/* core/ccss_pkg.sv */
/*
 * Types for the console control and single-step block.
 * Assumes ccss_regs.svh supplies the numeric constants.
 */
package ccss_pkg;
	typedef enum logic [1:0] {
		CCSS_PWR_OFF,
		CCSS_PWR_STANDBY,
		CCSS_PWR_ON
	} ccss_pwr_e;

	typedef enum logic [1:0] {
		CCSS_MON_REGISTER,
		CCSS_MON_NEXT_PAIR,
		CCSS_MON_OPERAND,
		CCSS_MON_FLOPS
	} ccss_mon_e;
endpackage

/* core/ccss_console.sv */
/*
 * Operator console control: power sequencing, start/load latches, stop lamp,
 * fetch/execute/run single stepping and circuit monitor source selection.
 * Assumes buttons are synchronous to mclk but may bounce, and that the state
 * sequencer honours the stop and hold levels driven here.
 * Every timing count runs on mclk itself, so the two-minute standby delay
 * needs a 34-bit counter; a bench may shorten it through STANDBY_CYC.
 * Panel buttons are plain high levels; the run switch is low while it
 * interrupts, and its debounced falling edge is the run request.
 */
`timescale 1ns/1ps
`include "ccss_regs.svh"

// Notes on behaviour
// - Standby lamp two minutes, then supplies on
// - Start and load never both set
// - Last pressed of start/load wins; power clears
// - Neither latch set forces idle in state 8
// - Stop lamp lit on state 8 decode
// - Stop lamp filtered against 1/8 alternation
// - State 3 shifts next address and timing
// - Fetch hold keeps sequencer in state 4
// - Execute hold lets state 4 pass
// - Only run clears holds to automatic
// - Fetch and execute holds mutually exclusive
// - Run pulse clears both holds together
// - Monitor offers four display source kinds
module ccss_console
	import ccss_pkg::*;
#(
	parameter longint unsigned STANDBY_CYC = `CCSS_STANDBY_CYC
) (
	input wire logic mclk, // Machine clock, 100 MHz.
	input wire logic rst_b, // Asynchronous reset, active low.
	input wire logic btn_power_on, // Power on button, high when pressed.
	input wire logic btn_power_off, // Power off button, high when pressed.
	input wire logic btn_start, // Start button.
	input wire logic btn_load, // Load button.
	input wire logic btn_stop, // Stop button, held level.
	input wire logic btn_fetch, // Fetch button.
	input wire logic btn_execute, // Execute button.
	input wire logic btn_run_b, // Run switch, low while interrupted.
	input wire logic state_bit_one, // Sequencer state bit one.
	input wire logic state_bit_two, // Sequencer state bit two.
	input wire logic state_bit_three, // Sequencer state bit three.
	input wire logic state_aux_bit, // Sequencer auxiliary state bit.
	input wire logic [3:0] seq_state, // Sequencer state number.
	input wire logic [1:0] mon_source_sel, // Monitor source kind selector.
	input wire logic [2:0] mon_reg_sel, // Circulating register index, 0 to 4.
	output logic standby_lamp, // Standby indicator.
	output logic power_on_lamp, // Power on indicator.
	output logic supply_enable, // Low voltage supplies enable.
	output logic start_latch, // Start latch and lamp.
	output logic load_latch, // Load latch and lamp.
	output logic seq_stop, // Force sequencer idle in state 8.
	output logic stop_lamp, // Filtered stop indicator.
	output logic shift_next_addr, // Shift next address register enable.
	output logic shift_timing, // Shift timing register enable.
	output logic fetch_hold_level, // Fetch hold, keeps state 4.
	output logic execute_hold_level, // Execute hold, lets state 4 pass.
	output logic execute_hold_relay, // Execute hold relay state.
	output logic automatic_mode, // No hold engaged.
	output ccss_mon_e mon_source, // Registered monitor source kind.
	output logic [2:0] mon_register // Registered register index.
);
	// Debounce and lamp filter windows, both counted in mclk cycles.
	localparam int unsigned DB_CYC = `CCSS_DEBOUNCE_CYC;
	localparam int unsigned SF_CYC = `CCSS_STOP_FILT_CYC;
	localparam int unsigned NB = `CCSS_BTN_COUNT;

	logic [NB-1:0] btn_raw;
	logic [NB-1:0] btn_press;
	logic run_level;
	logic run_prev;
	logic [15:0] run_cnt;
	logic run_pulse;
	ccss_pwr_e pwr_state;
	logic [33:0] standby_cnt;
	logic state8_decode;
	logic [15:0] stop_cnt;
	logic stop_filt;
	logic powered;

	assign btn_raw[`CCSS_BTN_PWR_ON] = btn_power_on;
	assign btn_raw[`CCSS_BTN_PWR_OFF] = btn_power_off;
	assign btn_raw[`CCSS_BTN_START] = btn_start;
	assign btn_raw[`CCSS_BTN_LOAD] = btn_load;
	assign btn_raw[`CCSS_BTN_FETCH] = btn_fetch;
	assign btn_raw[`CCSS_BTN_EXEC] = btn_execute;

	// A button counts only after it has held one level for the full window.
	genvar gi;
	generate
		for (gi = 0; gi < NB; gi++) begin : g_db
			logic [15:0] cnt;
			logic lvl;
			always_ff @(posedge mclk or negedge rst_b) begin
				if (!rst_b) begin
					cnt <= 16'h0000;
					lvl <= 1'b0;
				end else if (btn_raw[gi] == lvl) begin
					cnt <= 16'h0000;
				end else if (cnt == 16'(DB_CYC - 1)) begin
					cnt <= 16'h0000;
					lvl <= btn_raw[gi];
				end else begin
					cnt <= cnt + 16'h0001;
				end
			end
			logic lvl_d;
			always_ff @(posedge mclk or negedge rst_b) begin
				if (!rst_b) begin
					lvl_d <= 1'b0;
				end else begin
					lvl_d <= lvl;
				end
			end
			// The press pulse lasts one cycle, so a held button acts only once.
			assign btn_press[gi] = lvl & ~lvl_d;
		end
	endgenerate

	// The run switch is debounced too; its interruption is the reset event.
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			run_cnt <= 16'h0000;
			run_level <= 1'b1;
		end else if (btn_run_b == run_level) begin
			run_cnt <= 16'h0000;
		end else if (run_cnt == 16'(DB_CYC - 1)) begin
			run_cnt <= 16'h0000;
			run_level <= btn_run_b;
		end else begin
			run_cnt <= run_cnt + 16'h0001;
		end
	end

	// Both run stages reset high, the switch's idle level, so leaving reset
	// never looks like a run request.
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			run_prev <= 1'b1;
		end else begin
			run_prev <= run_level;
		end
	end

	assign run_pulse = run_prev & ~run_level;

	// Power sequencing; power off wins over a simultaneous power on.
	// Two minutes of mclk cycles do not fit 32 bits, hence the wider counter.
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			pwr_state <= CCSS_PWR_OFF;
			standby_cnt <= 34'h0;
		end else if (btn_press[`CCSS_BTN_PWR_OFF]) begin
			pwr_state <= CCSS_PWR_OFF;
			standby_cnt <= 34'h0;
		end else begin
			case (pwr_state)
				CCSS_PWR_OFF: begin
					if (btn_press[`CCSS_BTN_PWR_ON]) begin
						pwr_state <= CCSS_PWR_STANDBY;
						standby_cnt <= 34'h0;
					end
				end
				CCSS_PWR_STANDBY: begin
					if (standby_cnt == 34'(STANDBY_CYC - 1)) begin
						pwr_state <= CCSS_PWR_ON;
					end else begin
						standby_cnt <= standby_cnt + 34'h1;
					end
				end
				CCSS_PWR_ON: begin
					pwr_state <= CCSS_PWR_ON;
				end
				default: begin
					pwr_state <= CCSS_PWR_OFF;
				end
			endcase
		end
	end

	assign powered = (pwr_state == CCSS_PWR_ON);

	// The lamps follow the power state one cycle late, so the supplies and the
	// power lamp come on in the same cycle as the standby lamp goes dark.
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			standby_lamp <= 1'b0;
			power_on_lamp <= 1'b0;
			supply_enable <= 1'b0;
		end else begin
			standby_lamp <= (pwr_state == CCSS_PWR_STANDBY);
			power_on_lamp <= powered;
			supply_enable <= powered;
		end
	end

	// Start and load latches: a press sets its own and clears the other, so
	// the pair can only hold one of three combinations. Start wins a tie.
	// Losing power clears both, so neither the start nor the load lamp stays lit on an unpowered panel.
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			start_latch <= 1'b0;
			load_latch <= 1'b0;
		end else if (!powered) begin
			start_latch <= 1'b0;
			load_latch <= 1'b0;
		end else if (btn_press[`CCSS_BTN_START]) begin
			start_latch <= 1'b1;
			load_latch <= 1'b0;
		end else if (btn_press[`CCSS_BTN_LOAD]) begin
			start_latch <= 1'b0;
			load_latch <= 1'b1;
		end
	end

	// Neither latch set behaves exactly as a held stop button.
	// The stop button only gates the sequencer, so it needs no debounce.
	assign seq_stop = btn_stop | ~(start_latch | load_latch);

	// Only state 8 has bit one clear with bits two, three and aux all set.
	assign state8_decode = ~state_bit_one & state_bit_two & state_bit_three
		& state_aux_bit;

	// Brief excursions through state 1 would flicker the lamp, so the lamp
	// changes only after the decode has stayed put for the filter window.
	// The trade is a lamp that lags the sequencer by that window either way.
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			stop_cnt <= 16'h0000;
			stop_filt <= 1'b0;
		end else if (state8_decode == stop_filt) begin
			stop_cnt <= 16'h0000;
		end else if (stop_cnt == 16'(SF_CYC - 1)) begin
			stop_cnt <= 16'h0000;
			stop_filt <= state8_decode;
		end else begin
			stop_cnt <= stop_cnt + 16'h0001;
		end
	end

	assign stop_lamp = stop_filt;

	// Both shift enables are high for every cycle spent in state 3, one cycle
	// late; the registers they drive must tolerate that delay.
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			shift_next_addr <= 1'b0;
		end else begin
			shift_next_addr <= (seq_state == `CCSS_STATE_XFER);
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			shift_timing <= 1'b0;
		end else begin
			shift_timing <= (seq_state == `CCSS_STATE_XFER);
		end
	end

	// Holds: only the run interruption releases them; it outranks a press.
	// A press made while the run switch is still open is lost, not deferred.
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			fetch_hold_level <= 1'b0;
			execute_hold_level <= 1'b0;
		end else if (run_pulse || !run_level) begin
			fetch_hold_level <= 1'b0;
			execute_hold_level <= 1'b0;
		end else if (btn_press[`CCSS_BTN_FETCH]) begin
			fetch_hold_level <= 1'b1;
			execute_hold_level <= 1'b0;
		end else if (btn_press[`CCSS_BTN_EXEC]) begin
			fetch_hold_level <= 1'b0;
			execute_hold_level <= 1'b1;
		end
	end

	// The relay copy is what lets the sequencer pass state 4 while executing.
	assign execute_hold_relay = execute_hold_level;
	assign automatic_mode = ~(fetch_hold_level | execute_hold_level);

	// All four selector codes name a source kind, so the cast needs no guard.
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			mon_source <= CCSS_MON_REGISTER;
		end else begin
			mon_source <= ccss_mon_e'(mon_source_sel);
		end
	end

	// Out of range register indices fall back to register 0.
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			mon_register <= 3'h0;
		end else begin
			mon_register <= (mon_reg_sel > 3'h4) ? 3'h0 : mon_reg_sel;
		end
	end
endmodule

/* bench/ccss_console_assertions.sv */
/*
 * Checker for the console control block, bound to ccss_console.
 * Assumes it sees the console ports under their own names.
 */
`timescale 1ns/1ps
module ccss_console_assertions (
	input wire logic mclk, // Machine clock.
	input wire logic rst_b, // Reset, active low.
	input wire logic btn_run_b, // Run switch, low while open.
	input wire logic state_bit_one, // State bit one.
	input wire logic state_bit_two, // State bit two.
	input wire logic state_bit_three, // State bit three.
	input wire logic state_aux_bit, // Auxiliary state bit.
	input wire logic start_latch, // Start latch.
	input wire logic load_latch, // Load latch.
	input wire logic seq_stop, // Idle request.
	input wire logic stop_lamp, // Stop indicator.
	input wire logic [3:0] seq_state, // State number.
	input wire logic shift_next_addr, // Next address shift.
	input wire logic shift_timing, // Timing shift.
	input wire logic standby_lamp, // Standby indicator.
	input wire logic power_on_lamp, // Power on indicator.
	input wire logic supply_enable, // Supplies enable.
	input wire logic fetch_hold_level, // Fetch hold.
	input wire logic execute_hold_level, // Execute hold.
	input wire logic execute_hold_relay, // Execute relay.
	input wire logic automatic_mode // No hold engaged.
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_b);
	logic dec;
	assign dec = !state_bit_one && state_bit_two && state_bit_three && state_aux_bit;
	property p_excl; !(start_latch && load_latch); endproperty
	a_excl: assert property (p_excl) else $error("start and load both set");
	property p_idle; !start_latch && !load_latch |-> seq_stop; endproperty
	a_idle: assert property (p_idle) else $error("idle not forced");
	property p_pwr; standby_lamp |-> !supply_enable && !power_on_lamp; endproperty
	a_pwr: assert property (p_pwr) else $error("supplies on during standby");
	property p_lamp; $rose(stop_lamp) |-> $past(dec, 1) && $past(dec, 150); endproperty
	a_lamp: assert property (p_lamp) else $error("stop lamp lit too early");
	property p_dark; $fell(stop_lamp) |-> !$past(dec, 1) && !$past(dec, 150); endproperty
	a_dark: assert property (p_dark) else $error("stop lamp flickered off");
	property p_shift; seq_state == 4'h3 |=> shift_next_addr && shift_timing; endproperty
	a_shift: assert property (p_shift) else $error("no shift after state 3");
	property p_holdx; !(fetch_hold_level && execute_hold_level); endproperty
	a_holdx: assert property (p_holdx) else $error("both holds set");
	property p_relay; execute_hold_relay == execute_hold_level; endproperty
	a_relay: assert property (p_relay) else $error("relay disagrees");
	property p_auto; automatic_mode == !(fetch_hold_level || execute_hold_level); endproperty
	a_auto: assert property (p_auto) else $error("automatic mode wrong");
	property p_keep; (fetch_hold_level || execute_hold_level) && btn_run_b
		|=> fetch_hold_level || execute_hold_level; endproperty
	a_keep: assert property (p_keep) else $error("hold released without run");
	property p_runclr; $rose(automatic_mode) |-> !$past(btn_run_b, 2); endproperty
	a_runclr: assert property (p_runclr) else $error("holds cleared without run");
	c_start: cover property ($rose(start_latch));
	c_fetch: cover property ($rose(fetch_hold_level));
	c_lamp: cover property ($rose(stop_lamp));
endmodule
bind ccss_console ccss_console_assertions u_chk (.*);

/* bench/ccss_seq_model.sv */
/*
 * State sequencer model: runs 1,8,1,8,3,4,5 and repeats.
 * Assumes the console drives the idle and fetch hold levels.
 */
`timescale 1ns/1ps
module ccss_seq_model (
	input wire logic mclk, // Machine clock.
	input wire logic rst_b, // Reset, active low.
	input wire logic seq_stop, // Idle request.
	input wire logic fetch_hold_level, // Hold in state 4.
	output logic [3:0] seq_state, // State number.
	output logic [3:0] state_bits // One, two, three, aux.
);
	logic [2:0] idx;
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			idx <= 3'h0;
		end else if (seq_stop) begin
			idx <= 3'h1;
		end else if (!(idx == 3'h5 && fetch_hold_level)) begin
			idx <= (idx == 3'h6) ? 3'h0 : idx + 3'h1;
		end
	end
	always_comb begin
		case (idx)
			3'h1, 3'h3: seq_state = 4'h8;
			3'h4: seq_state = 4'h3;
			3'h5: seq_state = 4'h4;
			3'h6: seq_state = 4'h5;
			default: seq_state = 4'h1;
		endcase
	end
	assign state_bits = (seq_state == 4'h8) ? 4'h7 : 4'h8;
endmodule

/* bench/testbench.sv */
/*
 * Testbench for ccss_console with the sequencer model.
 * Assumes a short standby count of 1000 cycles.
 */
`timescale 1ns/1ps
module testbench;
	import ccss_pkg::*;
	logic mclk = 0, rst_b = 0, btn_stop = 0, btn_run_b = 1;
	logic [5:0] btn = 6'h00;
	logic [1:0] mon_source_sel = 2'h0;
	logic [2:0] mon_reg_sel = 3'h0, mon_register;
	logic [3:0] seq_state, bits;
	logic standby_lamp, power_on_lamp, supply_enable, start_latch, load_latch, seq_stop;
	logic stop_lamp, fetch_hold_level, execute_hold_level, execute_hold_relay, automatic_mode;
	ccss_mon_e mon_source;
	int bad_count = 0, checks = 0, cycles = 0, n4;
	always #5 mclk = ~mclk;
	ccss_console #(.STANDBY_CYC(1000)) u_ccss_console (.mclk(mclk), .rst_b(rst_b),
		.btn_power_on(btn[0]), .btn_power_off(btn[1]), .btn_start(btn[2]), .btn_load(btn[3]),
		.btn_stop(btn_stop), .btn_fetch(btn[4]), .btn_execute(btn[5]), .btn_run_b(btn_run_b),
		.state_bit_one(bits[3]), .state_bit_two(bits[2]), .state_bit_three(bits[1]),
		.state_aux_bit(bits[0]), .seq_state(seq_state), .mon_source_sel(mon_source_sel),
		.mon_reg_sel(mon_reg_sel), .standby_lamp(standby_lamp), .power_on_lamp(power_on_lamp),
		.supply_enable(supply_enable), .start_latch(start_latch), .load_latch(load_latch),
		.seq_stop(seq_stop), .stop_lamp(stop_lamp), .shift_next_addr(), .shift_timing(),
		.fetch_hold_level(fetch_hold_level), .execute_hold_level(execute_hold_level),
		.execute_hold_relay(execute_hold_relay), .automatic_mode(automatic_mode),
		.mon_source(mon_source), .mon_register(mon_register));
	ccss_seq_model u_ccss_seq_model (.mclk(mclk), .rst_b(rst_b), .seq_stop(seq_stop),
		.fetch_hold_level(fetch_hold_level), .seq_state(seq_state), .state_bits(bits));
	task report_and_stop;
		if (bad_count == 0 && checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task chk(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			bad_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Buttons must stay put 500 cycles, so each release waits longer; a press lasts n cycles.
	task push(input int i, input int n);
		btn[i] <= 1'b1;
		repeat (n) @(posedge mclk);
		btn[i] <= 1'b0;
		repeat (520) @(posedge mclk);
	endtask
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 40000) begin
			bad_count++;
			report_and_stop();
		end
	end
	initial begin
		repeat (4) @(posedge mclk);
		rst_b <= 1'b1;
		@(posedge mclk);
		chk({4'h0, start_latch, load_latch, seq_stop, standby_lamp}, 8'h02);
		push(2, 520);
		chk({7'h00, start_latch}, 8'h00);
		push(0, 520);
		chk({5'h00, standby_lamp, power_on_lamp, supply_enable}, 8'h04);
		repeat (1000) @(posedge mclk);
		chk({5'h00, standby_lamp, power_on_lamp, supply_enable}, 8'h03);
		push(2, 100);
		chk({7'h00, start_latch}, 8'h00);
		push(2, 520);
		chk({5'h00, start_latch, load_latch, seq_stop}, 8'h04);
		push(3, 520);
		chk({6'h00, start_latch, load_latch}, 8'h01);
		// The lamp lit while idling must ride out the run's states 1 and 8.
		n4 = 0;
		repeat (100) begin
			@(posedge mclk);
			n4 += (stop_lamp === 1'b1);
		end
		chk(8'(n4), 8'h64);
		push(4, 520);
		chk({seq_state, 1'b0, fetch_hold_level, execute_hold_level, automatic_mode}, 8'h44);
		chk({7'h00, stop_lamp}, 8'h00);
		push(5, 520);
		chk({5'h00, fetch_hold_level, execute_hold_level, execute_hold_relay}, 8'h03);
		n4 = 0;
		repeat (7) begin
			@(posedge mclk);
			n4 += (seq_state === 4'h4);
		end
		chk(8'(n4), 8'h01);
		btn_stop <= 1'b1;
		repeat (250) @(posedge mclk);
		chk({seq_state, 3'h0, stop_lamp}, 8'h81);
		btn_stop <= 1'b0;
		push(2, 520);
		chk({5'h00, fetch_hold_level, execute_hold_level, automatic_mode}, 8'h02);
		btn_run_b <= 1'b0;
		repeat (520) @(posedge mclk);
		btn_run_b <= 1'b1;
		repeat (520) @(posedge mclk);
		chk({5'h00, fetch_hold_level, execute_hold_level, automatic_mode}, 8'h01);
		for (int i = 0; i < 4; i++) begin
			mon_source_sel <= 2'(i);
			mon_reg_sel <= 3'(i + 2);
			repeat (3) @(posedge mclk);
			chk({3'h0, mon_source, mon_register}, {3'h0, 2'(i), 3'(i < 3 ? i + 2 : 0)});
		end
		push(1, 520);
		chk({5'h00, start_latch, load_latch, power_on_lamp}, 8'h00);
		report_and_stop();
	end
endmodule
